// *** design/aux_input_pkg.sv ***
// Package for the auxiliary input conditioning block.
// Assumes a 10 MHz clock and an APB slave with 32-bit data.
package aux_input_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_FUNCTION_SELECT = 8'h35;
   localparam logic [7:0] IDX_DIGITAL_CONFIG  = 8'h36;
   localparam logic [7:0] IDX_EVENT_STATUS    = 8'h37;
   localparam logic [7:0] IDX_EVENT_MASK      = 8'h38;
   localparam logic [9:0] ADDR_FUNCTION_SELECT = {IDX_FUNCTION_SELECT, 2'b00};
   localparam logic [9:0] ADDR_DIGITAL_CONFIG  = {IDX_DIGITAL_CONFIG, 2'b00};
   localparam logic [9:0] ADDR_EVENT_STATUS    = {IDX_EVENT_STATUS, 2'b00};
   localparam logic [9:0] ADDR_EVENT_MASK      = {IDX_EVENT_MASK, 2'b00};
   localparam logic [7:0] FUNCTION_SELECT_MASK = 8'h03;
   localparam logic [7:0] DIGITAL_CONFIG_MASK  = 8'h7f;
   localparam logic [7:0] EVENT_MASK_BITS      = 8'h03;
   localparam logic [7:0] FUNCTION_SELECT_RESET = 8'h03;
   localparam logic [7:0] DIGITAL_CONFIG_RESET  = 8'h00;
   localparam logic [7:0] EVENT_MASK_RESET      = 8'h00;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int INVERT_BIT    = 6;
   localparam int DETECT_BIT    = 5;
   localparam int PULSE_LSB     = 3;
   localparam int FILTER_LSB    = 0;
   localparam int STAT_EDGE_BIT = 0;
   localparam int STAT_FLT_BIT  = 1;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int US_DIV        = 1_000_000;
   localparam int CYC_PER_US    = CLK_HZ / US_DIV;
   localparam int PULSE_US_0    = 10;
   localparam int PULSE_US_1    = 100;
   localparam int PULSE_US_2    = 1000;
   localparam int PULSE_US_3    = 10000;
   localparam int FILT_US_0     = 0;
   localparam int FILT_US_1     = 5;
   localparam int FILT_US_2     = 10;
   localparam int FILT_US_3     = 20;
   localparam int FILT_US_4     = 30;
   localparam int FILT_US_5     = 50;
   localparam int FILT_US_6     = 75;
   localparam int FILT_US_7     = 100;
   localparam int CNT_W         = 17;

   typedef enum logic [1:0] {
      FN_DETECTOR_FAULT,
      FN_DIGITAL_FAULT,
      FN_DIGITAL_AND_WARN,
      FN_NONE
   } function_select_type;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic digital_fault;
      logic detector_fault;
      logic detector_warning;
   } events_type;
endpackage

// *** design/aux_input_conditioning.sv ***
// Conditioning and role selection for one auxiliary monitored input.
// Assumes an APB master on clk, and an asynchronous pin plus a
// supply detector level from the neighbouring comparator logic.
//
// Behaviour
// - Two-bit select: detector fault, digital fault, both, or none.
// - Combined role: digital input faults, detector only warns.
// - Invert bit flips the pin value before detection.
// - Detect bit: 0 follows level, 1 detects edges.
// - Edge pulse lasts 10, 100, 1000 or 10000 us by code.
// - Filter delay 0,5,10,20,30,50,75,100 us by code.
// - Filter drops pulses shorter than the selected delay.
module aux_input_conditioning
   import aux_input_pkg::*;
#(
   parameter int PULSE_LONG_CYC = PULSE_US_3 * CYC_PER_US
) (
   input  wire logic        clk,          // 10 MHz clock
   input  wire logic        rst,          // Synchronous reset, high
   input  wire apb_req_type apb_req,      // APB request
   output apb_rsp_type      apb_rsp,      // APB response
   input  wire logic        pin_in,       // Asynchronous pin level
   input  wire logic        detector_in,  // Detector trip level
   output logic             fault_out,    // Fault level
   output logic             warning_out,  // Warning level
   output logic             digital_out,  // Conditioned digital input
   output logic             irq           // Interrupt level
);
   // ----------------------------------------------------------------
   // Registers and bus
   // ----------------------------------------------------------------
   logic [7:0] function_select_r;
   logic [7:0] digital_config_r;
   logic [7:0] event_status_r;
   logic [7:0] event_mask_r;
   logic [7:0] status_set;
   logic       wr_en;
   logic       rd_en;
   logic [9:0] addr;
   logic       mapped;

   assign addr   = apb_req.paddr[9:0];
   assign wr_en  = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en  = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign mapped = (addr == ADDR_FUNCTION_SELECT) || (addr == ADDR_DIGITAL_CONFIG)
                || (addr == ADDR_EVENT_STATUS) || (addr == ADDR_EVENT_MASK);

   always_ff @(posedge clk) begin
      if (rst) begin
         function_select_r <= FUNCTION_SELECT_RESET;
         digital_config_r  <= DIGITAL_CONFIG_RESET;
         event_mask_r      <= EVENT_MASK_RESET;
      end else if (wr_en) begin
         if (addr == ADDR_FUNCTION_SELECT)
            function_select_r <= apb_req.pwdata[7:0] & FUNCTION_SELECT_MASK;
         if (addr == ADDR_DIGITAL_CONFIG)
            digital_config_r <= apb_req.pwdata[7:0] & DIGITAL_CONFIG_MASK;
         if (addr == ADDR_EVENT_MASK)
            event_mask_r <= apb_req.pwdata[7:0] & EVENT_MASK_BITS;
      end
   end

   // No wait state: answer in the access cycle, read data latched at setup
   always_ff @(posedge clk) begin
      if (rst) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !mapped;
         if (rd_en) begin
            case (addr)
               ADDR_FUNCTION_SELECT: apb_rsp.prdata <= {24'h000000, function_select_r};
               ADDR_DIGITAL_CONFIG:  apb_rsp.prdata <= {24'h000000, digital_config_r};
               ADDR_EVENT_STATUS:    apb_rsp.prdata <= {24'h000000, event_status_r};
               ADDR_EVENT_MASK:      apb_rsp.prdata <= {24'h000000, event_mask_r};
               default:              apb_rsp.prdata <= 32'h00000000;
            endcase
         end else if (!apb_req.psel) begin
            apb_rsp.prdata <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin synchroniser and inversion
   // ----------------------------------------------------------------
   logic [1:0] pin_sync_r;
   logic [1:0] det_sync_r;
   logic       pin_val;

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sync_r <= 2'b00;
         det_sync_r <= 2'b00;
      end else begin
         pin_sync_r <= {pin_sync_r[0], pin_in};
         det_sync_r <= {det_sync_r[0], detector_in};
      end
   end

   assign pin_val = pin_sync_r[1] ^ digital_config_r[INVERT_BIT];

   // ----------------------------------------------------------------
   // Glitch filter
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] filt_limit;
   logic [CNT_W-1:0] filt_cnt_r;
   logic             filt_r;

   always_comb begin
      case (digital_config_r[FILTER_LSB +: 3])
         3'h0:    filt_limit = CNT_W'(FILT_US_0 * CYC_PER_US);
         3'h1:    filt_limit = CNT_W'(FILT_US_1 * CYC_PER_US);
         3'h2:    filt_limit = CNT_W'(FILT_US_2 * CYC_PER_US);
         3'h3:    filt_limit = CNT_W'(FILT_US_3 * CYC_PER_US);
         3'h4:    filt_limit = CNT_W'(FILT_US_4 * CYC_PER_US);
         3'h5:    filt_limit = CNT_W'(FILT_US_5 * CYC_PER_US);
         3'h6:    filt_limit = CNT_W'(FILT_US_6 * CYC_PER_US);
         default: filt_limit = CNT_W'(FILT_US_7 * CYC_PER_US);
      endcase
   end

   // A change must persist limit cycles; any return to the old value restarts
   always_ff @(posedge clk) begin
      if (rst) begin
         filt_r     <= 1'b0;
         filt_cnt_r <= '0;
      end else if (pin_val == filt_r) begin
         filt_cnt_r <= '0;
      end else if (filt_cnt_r + CNT_W'(1) >= filt_limit) begin
         filt_r     <= pin_val;
         filt_cnt_r <= '0;
      end else begin
         filt_cnt_r <= filt_cnt_r + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Level or edge detection, stretched pulse
   // ----------------------------------------------------------------
   logic             filt_prev_r;
   logic             edge_seen;
   logic [CNT_W-1:0] pulse_len;
   logic [CNT_W-1:0] pulse_cnt_r;
   logic             digital_nxt;

   assign edge_seen = filt_r != filt_prev_r;

   always_comb begin
      case (digital_config_r[PULSE_LSB +: 2])
         2'h0:    pulse_len = CNT_W'(PULSE_US_0 * CYC_PER_US);
         2'h1:    pulse_len = CNT_W'(PULSE_US_1 * CYC_PER_US);
         2'h2:    pulse_len = CNT_W'(PULSE_US_2 * CYC_PER_US);
         default: pulse_len = CNT_W'(PULSE_LONG_CYC);
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         filt_prev_r <= 1'b0;
         pulse_cnt_r <= '0;
      end else begin
         filt_prev_r <= filt_r;
         if (edge_seen && digital_config_r[DETECT_BIT])
            pulse_cnt_r <= pulse_len;
         else if (pulse_cnt_r != '0)
            pulse_cnt_r <= pulse_cnt_r - CNT_W'(1);
      end
   end

   // Level mode follows filtered pin; edge mode is high while the pulse runs
   assign digital_nxt = digital_config_r[DETECT_BIT] ? (pulse_cnt_r != '0) : filt_r;

   // ----------------------------------------------------------------
   // Role selection and events
   // ----------------------------------------------------------------
   function_select_type fn;
   events_type          ev;

   assign fn = function_select_type'(function_select_r[1:0]);

   always_comb begin
      ev = '0;
      case (fn)
         FN_DETECTOR_FAULT: ev.detector_fault = det_sync_r[1];
         FN_DIGITAL_FAULT:  ev.digital_fault  = digital_nxt;
         FN_DIGITAL_AND_WARN: begin
            ev.digital_fault    = digital_nxt;
            ev.detector_warning = det_sync_r[1];
         end
         FN_NONE:           ev = '0;
         default:           ev = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         digital_out <= 1'b0;
         fault_out   <= 1'b0;
         warning_out <= 1'b0;
      end else begin
         digital_out <= digital_nxt;
         fault_out   <= ev.digital_fault || ev.detector_fault;
         warning_out <= ev.detector_warning;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status: set wins over write-one-to-clear
   // ----------------------------------------------------------------
   always_comb begin
      status_set                = 8'h00;
      status_set[STAT_EDGE_BIT] = edge_seen && digital_config_r[DETECT_BIT];
      status_set[STAT_FLT_BIT]  = (ev.digital_fault || ev.detector_fault) && !fault_out;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         event_status_r <= 8'h00;
      end else if (wr_en && addr == ADDR_EVENT_STATUS) begin
         event_status_r <= (event_status_r & ~apb_req.pwdata[7:0]) | status_set;
      end else begin
         event_status_r <= event_status_r | status_set;
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(event_status_r & event_mask_r);
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_none_no_fault: assert property (@(posedge clk) disable iff (rst)
      (fn == FN_NONE) |=> !fault_out && !warning_out)
      else $error("fault or warning with no function selected");

   a_combined_warn_only: assert property (@(posedge clk) disable iff (rst)
      (fn == FN_DIGITAL_AND_WARN && det_sync_r[1] && !digital_nxt) |=> !fault_out)
      else $error("detector raised a fault in combined role");

   a_invert_flips: assert property (@(posedge clk) disable iff (rst)
      pin_val == (pin_sync_r[1] ^ digital_config_r[INVERT_BIT]))
      else $error("inversion not applied");

   a_level_follows: assert property (@(posedge clk) disable iff (rst)
      (!digital_config_r[DETECT_BIT] && $stable(digital_config_r)) |=> digital_out == $past(filt_r))
      else $error("level mode output does not follow input");

   a_pulse_start: assert property (@(posedge clk) disable iff (rst)
      (edge_seen && digital_config_r[DETECT_BIT]) |=> pulse_cnt_r == $past(pulse_len))
      else $error("edge pulse not loaded with selected length");

   a_short_pulse_len: assert property (@(posedge clk) disable iff (rst)
      (edge_seen && digital_config_r[DETECT_BIT] && digital_config_r[PULSE_LSB +: 2] == 2'h0
       && $stable(digital_config_r))
      |=> (pulse_cnt_r != '0) [*8])
      else $error("10 us pulse ended early");

   a_filter_limit: assert property (@(posedge clk) disable iff (rst)
      digital_config_r[FILTER_LSB +: 3] == 3'h1 |-> filt_limit == CNT_W'(50))
      else $error("5 us filter limit wrong");

   a_glitch_blocked: assert property (@(posedge clk) disable iff (rst)
      (filt_limit != '0 && pin_val != filt_r && filt_cnt_r == '0) |=> $stable(filt_r))
      else $error("filter passed a one cycle change");

   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      function_select_r[7:2] == 6'h00 && !digital_config_r[7])
      else $error("reserved bits set");

   c_edge_pulse: cover property (@(posedge clk) disable iff (rst)
      edge_seen && digital_config_r[DETECT_BIT]);
   c_combined_warn: cover property (@(posedge clk) disable iff (rst)
      fn == FN_DIGITAL_AND_WARN && warning_out);
   c_irq: cover property (@(posedge clk) disable iff (rst) irq);
endmodule

// *** verification/pin_source.sv ***
// Model of the external signal on the auxiliary pin and of the
// supply detector level beside it. Assumes the bench calls its tasks.
module pin_source (
   input  wire logic clk,         // Bench clock
   output logic      pin_in,      // Pin level
   output logic      detector_in  // Detector trip level
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pin_in = 1'b0;
      detector_in = 1'b0;
   end
   task automatic drive(input logic v);
      @(posedge clk);
      pin_in <= v;
   endtask
   task automatic set_det(input logic v);
      @(posedge clk);
      detector_in <= v;
   endtask
   // Inverts the pin for n cycles, then restores it
   task automatic glitch(input int n);
      @(posedge clk);
      pin_in <= ~pin_in;
      repeat (n) @(posedge clk);
      pin_in <= ~pin_in;
   endtask
endmodule

// *** verification/aux_input_function_conditioning_tb.sv ***
// Self-checking bench for the auxiliary input conditioning block.
// Assumes the pin model and a 10 MHz clock; APB master in this module.
module aux_input_function_conditioning_tb
   import aux_input_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   apb_req_type req;
   apb_rsp_type rsp;
   logic        pin, det, fault, warn, dout, irq;
   int          n_fail = 0;
   int          total_checks = 0;
   logic [31:0] rd;
   logic        err;
   always #50 clk = ~clk;
   pin_source i_src (.clk(clk), .pin_in(pin), .detector_in(det));
   aux_input_conditioning #(.PULSE_LONG_CYC(200)) i_dut (
      .clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .pin_in(pin),
      .detector_in(det), .fault_out(fault), .warning_out(warn),
      .digital_out(dout), .irq(irq));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      req.paddr <= {22'h0, a};
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.pwdata <= d;
      @(posedge clk);
      req.penable <= 1'b1;
      // Answer is judged at the rising edge, with the request still standing
      @(posedge clk);
      while (rsp.pready !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      if (k == 50) chk("pready", 32'h1, 32'h0);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rdchk(input string name, input logic [9:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd);
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic measure(input int exp);
      int k, n;
      k = 0;
      n = 0;
      while (dout !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      while (dout === 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      chk("pulse_len", exp, n);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rdchk("fs_reset", ADDR_FUNCTION_SELECT, 32'h3);
      rdchk("cfg_reset", ADDR_DIGITAL_CONFIG, 32'h0);
      rdchk("mask_reset", ADDR_EVENT_MASK, 32'h0);
      apb(1'b1, ADDR_FUNCTION_SELECT, 32'hffff_fffe);
      rdchk("fs_unused", ADDR_FUNCTION_SELECT, 32'h2);
      apb(1'b1, ADDR_DIGITAL_CONFIG, 32'hffff_ffff);
      rdchk("cfg_unused", ADDR_DIGITAL_CONFIG, 32'h7f);
      apb(1'b1, 10'h3fc, 32'h5a);
      chk("unmapped_err", 32'h1, err);
      rdchk("unmapped_rd", 10'h3fc, 32'h0);
      apb(1'b1, ADDR_DIGITAL_CONFIG, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_roles();
      logic [1:0] exp_fw [0:3];
      exp_fw = '{2'b10, 2'b00, 2'b01, 2'b00};
      i_src.set_det(1'b1);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_FUNCTION_SELECT, c);
         settle(8);
         chk("role_fault_warn", exp_fw[c], {fault, warn});
      end
      i_src.drive(1'b1);
      apb(1'b1, ADDR_FUNCTION_SELECT, 32'h1);
      settle(10);
      chk("digital_fault", 32'h2, {fault, warn});
      apb(1'b1, ADDR_FUNCTION_SELECT, 32'h2);
      settle(8);
      chk("combined_fault_warn", 32'h3, {fault, warn});
      i_src.set_det(1'b0);
      i_src.drive(1'b0);
      apb(1'b1, ADDR_FUNCTION_SELECT, 32'h3);
      $display("test roles done");
   endtask
   task automatic t_invert();
      settle(8);
      chk("level_plain", 32'h0, dout);
      apb(1'b1, ADDR_DIGITAL_CONFIG, 32'h40);
      settle(8);
      chk("level_inverted", 32'h1, dout);
      i_src.drive(1'b1);
      settle(8);
      chk("inverted_high_pin", 32'h0, dout);
      i_src.drive(1'b0);
      apb(1'b1, ADDR_DIGITAL_CONFIG, 32'h0);
      settle(8);
      $display("test invert done");
   endtask
   task automatic t_filter();
      logic seen;
      seen = 1'b0;
      apb(1'b1, ADDR_DIGITAL_CONFIG, 32'h1);
      // Watch while the short glitch is on the pin, not only after it
      fork
         i_src.glitch(FILT_US_1 * CYC_PER_US - 10);
         repeat (80) begin
            @(negedge clk);
            seen = seen | dout;
         end
      join
      chk("glitch_dropped", 32'h0, seen);
      // The passed level is checked while the long pulse still lasts
      fork
         i_src.glitch(FILT_US_1 * CYC_PER_US + 20);
         begin
            settle(FILT_US_1 * CYC_PER_US + 10);
            chk("long_pulse_passed", 32'h1, dout);
         end
      join
      settle(80);
      apb(1'b1, ADDR_DIGITAL_CONFIG, 32'h0);
      $display("test filter done");
   endtask
   task automatic t_edge();
      int codes [0:2];
      int lens [0:2];
      codes = '{0, 1, 3};
      lens = '{PULSE_US_0 * CYC_PER_US, PULSE_US_1 * CYC_PER_US, 200};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ADDR_DIGITAL_CONFIG, 32'h20 | (codes[i] << PULSE_LSB));
         settle(10);
         i_src.drive(1'b1);
         measure(lens[i]);
         chk("level_ignored", 32'h0, dout);
         i_src.drive(1'b0);
         measure(lens[i]);
      end
      $display("test edge done");
   endtask
   task automatic t_irq();
      apb(1'b1, ADDR_EVENT_STATUS, 32'h3);
      rdchk("status_cleared", ADDR_EVENT_STATUS, 32'h0);
      apb(1'b1, ADDR_EVENT_MASK, 32'h1);
      settle(3);
      chk("irq_idle", 32'h0, irq);
      i_src.glitch(20);
      settle(10);
      chk("irq_raised", 32'h1, irq);
      rdchk("status_edge", ADDR_EVENT_STATUS, 32'h1);
      apb(1'b1, ADDR_EVENT_STATUS, 32'h1);
      settle(3);
      chk("irq_cleared", 32'h0, irq);
      apb(1'b1, ADDR_EVENT_MASK, 32'h0);
      i_src.glitch(20);
      settle(10);
      chk("irq_masked", 32'h0, irq);
      rdchk("status_masked_set", ADDR_EVENT_STATUS, 32'h1);
      $display("test irq done");
   endtask
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      req <= '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_roles();
      t_invert();
      t_filter();
      t_edge();
      t_irq();
      conclude();
   end
   // Tests need about 3200 cycles; allow a wide margin
   initial begin
      #3_000_000;
      n_fail++;
      conclude();
   end
endmodule
